// ===== logic/aael_pkg.sv
package aael_pkg;
    // clock and link timing
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_HZ = 32_000;
    localparam int BAUD_HZ = 4_000_000;
    localparam int TIMER_PERIOD = CLK_HZ / SAMPLE_HZ;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int TIMER_W = 11;
    localparam int BITCNT_W = 4;
    // phase lock: wanted timer count when a request arrives, and trim limit
    localparam logic [10:0] PLL_TARGET = 11'h4C0;
    localparam logic [10:0] PLL_TRIM_MAX = 11'h010;
    // averaging
    localparam int AVG_COUNT = 64;
    localparam int AVG_SHIFT = 6;
    localparam int ADC_W = 12;
    localparam logic [11:0] ADC_MID = 12'h800;
    // frame
    localparam int FRAME_BITS = 10;
    localparam int RESP_BYTES = 11;
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
    localparam logic [3:0] IDX_CMD = 4'h0;
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_ANGLE0 = 4'h2;
    localparam logic [3:0] IDX_ANGLE1 = 4'h3;
    localparam logic [3:0] IDX_ANGLE2 = 4'h4;
    localparam logic [3:0] IDX_ENC_ID = 4'h5;
    localparam logic [3:0] IDX_ALARM = 4'h9;
    localparam logic [3:0] IDX_CRC = 4'hA;
    // q21_fraction_format constants, 1.0 = 2^21
    localparam int Q_FRAC = 21;
    localparam logic signed [24:0] Q_ONE = 25'sh0200000;
    localparam logic signed [24:0] Q_HALF = 25'sh0100000;
    localparam logic signed [24:0] Q_QUARTER = 25'sh0080000;
    localparam logic signed [24:0] Q_EIGHTH = 25'sh0040000;
    localparam logic signed [24:0] Q_3EIGHTH = 25'sh00C0000;
    localparam logic signed [24:0] X_LATCH_OFFSET_TABLE [2] = '{25'sh0000000, 25'sh0200000};
    localparam logic signed [24:0] Y_LATCH_OFFSET_TABLE [2] = '{25'sh0200000, 25'sh0000000};
    localparam logic [7:0] STATUS_FULL_TURN = 8'h01;
endpackage : aael_pkg

// ===== logic/aael_txbuf.sv
`timescale 1ns/100ps
module aael_txbuf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule : aael_txbuf

// ===== logic/aael_top.sv
`timescale 1ns/100ps
// Behaviour
// - sine and cosine conversions start together on each 32 kHz pacing timer tick.
// - each channel result is the average of 64 consecutive raw samples.
// - at the end of an averaged conversion both results and both Hall latches are captured and a new angle follows.
// - a position request fills a response buffer which a sequencer streams to the transmitter unaided.
// - the pacing timer period is trimmed so its phase locks to the host request rate.
// - the two Hall quadrant latches pick the mechanical half so the angle covers a full turn.
// - angle is 0.25 minus half the phase, offset by the x latch, the y latch, or 0.5 minus the y latch by range.
// - a stored reference offset is subtracted from every absolute angle.
// - offset and amplitude corrections are only meaningful once a full rotation has been observed.
// - the link is a 4 Mbaud asynchronous UART on a half-duplex bus.
// - each accepted request command is answered with the fields assigned to it.
// - a full-data request returns 11 bytes: command, status, angle, id, three zero multi-turn bytes, a zero alarm byte and CRC.
// - the single-turn angle travels as a 3-byte field.
module aael_top
    import aael_pkg::*;
#(
    parameter logic [7:0] FULL_DATA_REQUEST = 8'h03,
    parameter logic [7:0] ENCODER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] CRC_POLY = 8'h07
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    output logic ADC_START,
    input wire logic ADC_VALID,
    input wire logic [ADC_W-1:0] ADC_SIN,
    input wire logic [ADC_W-1:0] ADC_COS,
    input wire logic HALL_QUADRANT_X,
    input wire logic HALL_QUADRANT_Y,
    output logic ATAN_START,
    output logic signed [ADC_W:0] ATAN_SIN,
    output logic signed [ADC_W:0] ATAN_COS,
    input wire logic ATAN_DONE,
    input wire logic signed [23:0] ATAN_PHASE,
    input wire logic [Q_FRAC-1:0] ANGLE_OFFSET,
    output logic [Q_FRAC-1:0] ANGLE,
    output logic FULL_TURN_SEEN,
    input wire logic RX,
    output logic TX,
    output logic TX_OE
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} aael_rx_e;
    typedef enum {TX_IDLE, TX_FILL, TX_FETCH, TX_LOAD, TX_BIT} aael_tx_e;

    logic [1:0] rst_pipe_reg;
    logic rst_n;
    logic [2:0] sync1_reg, sync2_reg;
    logic rx_s, qx_s, qy_s;
    logic [TIMER_W-1:0] timer_reg, period_reg;
    logic tick;
    logic [6:0] avg_cnt_reg;
    logic [ADC_W+AVG_SHIFT-1:0] sum_sin_reg, sum_cos_reg;
    logic conv_done;
    logic qx_cap_reg, qy_cap_reg;
    logic [3:0] seen_reg;
    aael_rx_e rx_state;
    logic [BITCNT_W-1:0] rx_cyc_reg, rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic req;
    aael_tx_e tx_state;
    logic [BUF_AW-1:0] idx_reg;
    logic [BITCNT_W-1:0] tx_cyc_reg, tx_bit_reg;
    logic [9:0] tx_shift_reg;
    logic [7:0] crc_reg, fill_byte, rd_byte;
    logic [Q_FRAC-1:0] angle_snap_reg;
    logic full_snap_reg;

    function automatic logic [7:0] aael_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : aael_crc8

    function automatic logic [Q_FRAC-1:0] aael_angle(input logic signed [23:0] phase, input logic qx,
                                                    input logic qy, input logic [Q_FRAC-1:0] ofs);
        logic signed [24:0] ang;
        logic signed [24:0] abs_a;
        logic [Q_FRAC-1:0] turn;
        ang = Q_QUARTER - (25'(phase) >>> 1);
        if (ang <= Q_3EIGHTH && ang > Q_EIGHTH) begin
            abs_a = X_LATCH_OFFSET_TABLE[qx] + ang;
        end else if (ang > Q_3EIGHTH) begin
            abs_a = Y_LATCH_OFFSET_TABLE[qy] + ang;
        end else begin
            abs_a = Q_HALF - Y_LATCH_OFFSET_TABLE[qy] + ang;
        end
        // two electrical periods per turn, so halve; a latch offset of 1.0 is half a turn
        turn = abs_a[Q_FRAC:1];
        // reference offset removed, wraps modulo one turn
        return turn - ofs;
    endfunction : aael_angle

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_pipe_reg <= 2'h0;
        end else if (CE) begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end else if (CE) begin
            sync1_reg <= {RX, HALL_QUADRANT_Y, HALL_QUADRANT_X};
            sync2_reg <= sync1_reg;
        end
    end
    assign rx_s = sync2_reg[2];
    assign qy_s = sync2_reg[1];
    assign qx_s = sync2_reg[0];

    assign tick = (timer_reg >= period_reg);
    assign ADC_START = CE & tick;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_reg <= '0;
        end else if (CE) begin
            timer_reg <= tick ? '0 : timer_reg + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= TIMER_W'(TIMER_PERIOD - 1);
        end else if (CE && req) begin
            if (timer_reg > PLL_TARGET && period_reg > TIMER_W'(TIMER_PERIOD - 1) - PLL_TRIM_MAX) begin
                period_reg <= period_reg - 1'b1;
            end else if (timer_reg < PLL_TARGET && period_reg < TIMER_W'(TIMER_PERIOD - 1) + PLL_TRIM_MAX) begin
                period_reg <= period_reg + 1'b1;
            end
        end
    end

    assign conv_done = ADC_VALID && (avg_cnt_reg == 7'(AVG_COUNT - 1));

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            avg_cnt_reg <= '0;
            sum_sin_reg <= '0;
            sum_cos_reg <= '0;
        end else if (CE && tick) begin
            avg_cnt_reg <= '0;
            sum_sin_reg <= '0;
            sum_cos_reg <= '0;
        // count parks at 64, so late samples cannot start a second result
        end else if (CE && ADC_VALID && avg_cnt_reg < 7'(AVG_COUNT)) begin
            avg_cnt_reg <= avg_cnt_reg + 1'b1;
            sum_sin_reg <= sum_sin_reg + (ADC_W + AVG_SHIFT)'(ADC_SIN);
            sum_cos_reg <= sum_cos_reg + (ADC_W + AVG_SHIFT)'(ADC_COS);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ATAN_SIN <= '0;
            ATAN_COS <= '0;
            qx_cap_reg <= 1'b0;
            qy_cap_reg <= 1'b0;
            ATAN_START <= 1'b0;
        end else if (CE) begin
            ATAN_START <= conv_done;
            if (conv_done) begin
                ATAN_SIN <= $signed({1'b0, 12'((sum_sin_reg + 18'(ADC_SIN)) >> AVG_SHIFT)}) - $signed({1'b0, ADC_MID});
                ATAN_COS <= $signed({1'b0, 12'((sum_cos_reg + 18'(ADC_COS)) >> AVG_SHIFT)}) - $signed({1'b0, ADC_MID});
                qx_cap_reg <= qx_s;
                qy_cap_reg <= qy_s;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ANGLE <= '0;
        end else if (CE && ATAN_DONE) begin
            ANGLE <= aael_angle(ATAN_PHASE, qx_cap_reg, qy_cap_reg, ANGLE_OFFSET);
        end
    end

    // full rotation tracked by all quadrant pairs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= '0;
        end else if (CE && ATAN_START) begin
            seen_reg[{qy_cap_reg, qx_cap_reg}] <= 1'b1;
        end
    end
    assign FULL_TURN_SEEN = &seen_reg;

    // receiver, mid-bit sampling at 4 Mbaud
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_cyc_reg <= '0;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
        end else if (CE) begin
            case (rx_state)
                RX_IDLE: begin
                    rx_cyc_reg <= '0;
                    if (!rx_s && tx_state == TX_IDLE) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    rx_cyc_reg <= rx_cyc_reg + 1'b1;
                    if (rx_cyc_reg == BITCNT_W'(BIT_CYCLES / 2 - 1)) begin
                        rx_cyc_reg <= '0;
                        rx_bit_reg <= '0;
                        rx_state <= rx_s ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    rx_cyc_reg <= rx_cyc_reg + 1'b1;
                    if (rx_cyc_reg == BITCNT_W'(BIT_CYCLES - 1)) begin
                        rx_cyc_reg <= '0;
                        rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                        if (rx_bit_reg == 4'h7) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    rx_cyc_reg <= rx_cyc_reg + 1'b1;
                    if (rx_cyc_reg == BITCNT_W'(BIT_CYCLES - 1)) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // only the full-data command is answered
    assign req = rx_state == RX_STOP && rx_cyc_reg == BITCNT_W'(BIT_CYCLES - 1) && rx_s
                 && rx_shift_reg == FULL_DATA_REQUEST && tx_state == TX_IDLE;

    // angle as three bytes, low byte first
    always_comb begin
        case (idx_reg)
            IDX_CMD: fill_byte = FULL_DATA_REQUEST;
            IDX_STATUS: fill_byte = full_snap_reg ? STATUS_FULL_TURN : 8'h00;
            IDX_ANGLE0: fill_byte = angle_snap_reg[7:0];
            IDX_ANGLE1: fill_byte = angle_snap_reg[15:8];
            IDX_ANGLE2: fill_byte = {3'h0, angle_snap_reg[20:16]};
            IDX_ENC_ID: fill_byte = ENCODER_ID;
            IDX_CRC: fill_byte = crc_reg;
            default: fill_byte = 8'h00;
        endcase
    end

    // buffer filled then streamed by the sequencer
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            idx_reg <= '0;
            crc_reg <= '0;
            tx_cyc_reg <= '0;
            tx_bit_reg <= '0;
            tx_shift_reg <= 10'h3FF;
            angle_snap_reg <= '0;
            full_snap_reg <= 1'b0;
        end else if (CE) begin
            case (tx_state)
                TX_IDLE: begin
                    if (req) begin
                        angle_snap_reg <= ANGLE;
                        full_snap_reg <= FULL_TURN_SEEN;
                        idx_reg <= '0;
                        crc_reg <= '0;
                        tx_state <= TX_FILL;
                    end
                end
                TX_FILL: begin
                    crc_reg <= aael_crc8(crc_reg, fill_byte);
                    idx_reg <= idx_reg + 1'b1;
                    if (idx_reg == IDX_CRC) begin
                        idx_reg <= '0;
                        tx_state <= TX_FETCH;
                    end
                end
                TX_FETCH: tx_state <= TX_LOAD;
                TX_LOAD: begin
                    tx_shift_reg <= {1'b1, rd_byte, 1'b0};
                    tx_cyc_reg <= '0;
                    tx_bit_reg <= '0;
                    tx_state <= TX_BIT;
                end
                TX_BIT: begin
                    tx_cyc_reg <= tx_cyc_reg + 1'b1;
                    if (tx_cyc_reg == BITCNT_W'(BIT_CYCLES - 1)) begin
                        tx_cyc_reg <= '0;
                        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        tx_bit_reg <= tx_bit_reg + 1'b1;
                        if (tx_bit_reg == BITCNT_W'(FRAME_BITS - 1)) begin
                            idx_reg <= idx_reg + 1'b1;
                            tx_state <= (idx_reg == IDX_CRC) ? TX_IDLE : TX_FETCH;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    aael_txbuf #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH),
        .AW(BUF_AW)
    ) u_txbuf (
        .clk(CLK),
        .rst_n(rst_n),
        .ce(CE),
        .we(tx_state == TX_FILL),
        .waddr(idx_reg),
        .wdata(fill_byte),
        .raddr(idx_reg),
        .rdata(rd_byte)
    );

    assign TX = tx_shift_reg[0];
    // driver on only during the reply
    assign TX_OE = (tx_state == TX_FETCH) || (tx_state == TX_LOAD) || (tx_state == TX_BIT);
endmodule : aael_top

// ===== testbench/aael_top_props.sv
`timescale 1ns/100ps
module aael_chk
    import aael_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic ADC_START,
    input wire logic ADC_VALID,
    input wire logic ATAN_START,
    input wire logic signed [ADC_W:0] ATAN_SIN,
    input wire logic signed [ADC_W:0] ATAN_COS,
    input wire logic ATAN_DONE,
    input wire logic [Q_FRAC-1:0] ANGLE,
    input wire logic FULL_TURN_SEEN,
    input wire logic TX,
    input wire logic TX_OE
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    int per_cnt;
    int val_cnt;
    int oe_cnt;
    // zero means no tick seen yet, so the first period is not judged
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            per_cnt <= 0;
            val_cnt <= 0;
            oe_cnt <= 0;
        end else begin
            per_cnt <= ADC_START ? 1 : (per_cnt != 0 ? per_cnt + 1 : 0);
            val_cnt <= ADC_START ? 0 : (ADC_VALID ? val_cnt + 1 : val_cnt);
            oe_cnt <= TX_OE ? oe_cnt + 1 : 0;
        end
    end
    property p_period;
        ADC_START && per_cnt != 0 |-> per_cnt inside {[1234:1266]};
    endproperty
    a_period: assert property (p_period) else $error("pacing period out of trim range");
    property p_atan_cause;
        ATAN_START |-> val_cnt == 64;
    endproperty
    a_atan_cause: assert property (p_atan_cause) else $error("conversion not after 64 samples");
    property p_atan_answer;
        ADC_VALID && !ADC_START && val_cnt == 63 |=> ATAN_START;
    endproperty
    a_atan_answer: assert property (p_atan_answer) else $error("64th sample not answered");
    property p_atan_hold;
        !ATAN_START |-> $stable(ATAN_SIN) && $stable(ATAN_COS);
    endproperty
    a_atan_hold: assert property (p_atan_hold) else $error("channel result moved");
    property p_angle_cause;
        !$stable(ANGLE) |-> $past(ATAN_DONE);
    endproperty
    a_angle_cause: assert property (p_angle_cause) else $error("angle moved without phase");
    property p_tx_idle;
        !TX_OE |-> TX;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("line low while released");
    property p_oe_lead;
        $rose(TX_OE) |-> TX [*2] ##1 !TX;
    endproperty
    a_oe_lead: assert property (p_oe_lead) else $error("start bit not two cycles after enable");
    property p_bit_low;
        $fell(TX) |-> (!TX) [*8] ##1 !TX ##1 !TX;
    endproperty
    a_bit_low: assert property (p_bit_low) else $error("low bit shorter than ten cycles");
    property p_bit_high;
        $rose(TX) |-> TX [*8] ##1 TX ##1 TX;
    endproperty
    a_bit_high: assert property (p_bit_high) else $error("high bit shorter than ten cycles");
    property p_frame_len;
        $fell(TX_OE) |-> oe_cnt == 1122;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("reply frame length wrong");
    c_conv: cover property (ATAN_START);
    c_frame: cover property ($fell(TX_OE));
    c_turn: cover property ($rose(FULL_TURN_SEEN));
endmodule : aael_chk

bind aael_top aael_chk aael_chk_inst (.CLK(CLK), .RESET_N(RESET_N), .ADC_START(ADC_START),
    .ADC_VALID(ADC_VALID), .ATAN_START(ATAN_START), .ATAN_SIN(ATAN_SIN), .ATAN_COS(ATAN_COS),
    .ATAN_DONE(ATAN_DONE), .ANGLE(ANGLE), .FULL_TURN_SEEN(FULL_TURN_SEEN), .TX(TX), .TX_OE(TX_OE));

// ===== testbench/aael_host.sv
`timescale 1ns/100ps
module aael_host
    import aael_pkg::*;
(
    input wire logic clk,
    input wire logic tx,
    input wire logic tx_oe,
    output logic rx
);
    logic drv = 1'b1;
    logic drv_en = 1'b0;
    // shared pair, bias resistors pull it high when undriven
    assign rx = tx_oe ? tx : (drv_en ? drv : 1'b1);
    // low start, data lsb first, high stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        int i;
        f = {1'b1, b, 1'b0};
        for (i = 0; i < FRAME_BITS; i++) begin
            @(posedge clk);
            drv_en <= 1'b1;
            drv <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge clk);
        end
        @(posedge clk);
        drv_en <= 1'b0;
    endtask : send_byte
    // mid-bit sampling at the link rate
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int i;
        b = 8'h00;
        ok = 1'b0;
        for (i = 0; i < 3000 && !(tx_oe === 1'b1 && tx === 1'b0); i++) @(negedge clk);
        if (i == 3000) return;
        repeat (BIT_CYCLES / 2) @(negedge clk);
        ok = (tx === 1'b0);
        for (i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge clk);
            b[i] = tx;
        end
        repeat (BIT_CYCLES) @(negedge clk);
        ok = ok && (tx === 1'b1);
    endtask : recv_byte
endmodule : aael_host

// ===== testbench/aael_top_tb.sv
`timescale 1ns/100ps
module aael_top_tb
    import aael_pkg::*;
;
    localparam logic [7:0] REQ = 8'h03;
    localparam logic [7:0] ENC_ID = 8'h6B; // arbitrary value
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic CE = 1'b1;
    logic ADC_VALID = 1'b0;
    logic [ADC_W-1:0] ADC_SIN = 12'h800;
    logic [ADC_W-1:0] ADC_COS = 12'h800;
    logic HALL_QUADRANT_X = 1'b0;
    logic HALL_QUADRANT_Y = 1'b0;
    logic ATAN_DONE = 1'b0;
    logic signed [23:0] ATAN_PHASE = 24'h000000;
    logic [Q_FRAC-1:0] ANGLE_OFFSET = 21'h000000;
    logic ADC_START, ATAN_START, FULL_TURN_SEEN, RX, TX, TX_OE;
    logic signed [ADC_W:0] ATAN_SIN, ATAN_COS;
    logic [Q_FRAC-1:0] ANGLE;
    int err_total = 0;
    int n_tests = 0;

    aael_top #(.FULL_DATA_REQUEST(REQ), .ENCODER_ID(ENC_ID), .CRC_POLY(8'h07)) aael_top_inst (
        .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .ADC_START(ADC_START), .ADC_VALID(ADC_VALID),
        .ADC_SIN(ADC_SIN), .ADC_COS(ADC_COS), .HALL_QUADRANT_X(HALL_QUADRANT_X),
        .HALL_QUADRANT_Y(HALL_QUADRANT_Y), .ATAN_START(ATAN_START), .ATAN_SIN(ATAN_SIN),
        .ATAN_COS(ATAN_COS), .ATAN_DONE(ATAN_DONE), .ATAN_PHASE(ATAN_PHASE), .ANGLE_OFFSET(ANGLE_OFFSET),
        .ANGLE(ANGLE), .FULL_TURN_SEEN(FULL_TURN_SEEN), .RX(RX), .TX(TX), .TX_OE(TX_OE));
    aael_host aael_host_inst (.clk(CLK), .tx(TX), .tx_oe(TX_OE), .rx(RX));

    initial begin
        forever #12.5 CLK = ~CLK;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wait_start;
        int i;
        @(negedge CLK);
        for (i = 0; i < 1400 && ADC_START !== 1'b1; i++) @(negedge CLK);
        if (ADC_START !== 1'b1) begin
            err_total++;
            end_sim();
        end
    endtask : wait_start

    function automatic logic [20:0] exp_angle(input logic qx, input logic qy, input logic [23:0] ph,
                                              input logic [20:0] ofs);
        logic signed [24:0] a;
        logic signed [24:0] s;
        a = Q_QUARTER - ($signed({ph[23], ph}) >>> 1);
        if (a > Q_EIGHTH && a <= Q_3EIGHTH) begin
            s = X_LATCH_OFFSET_TABLE[qx] + a;
        end else if (a > Q_3EIGHTH) begin
            s = Y_LATCH_OFFSET_TABLE[qy] + a;
        end else begin
            s = Q_HALF - Y_LATCH_OFFSET_TABLE[qy] + a;
        end
        // two electrical periods make one turn, so halve and wrap
        return s[21:1] - ofs;
    endfunction : exp_angle

    task automatic t_pacing;
        int n;
        wait_start();
        for (n = 1; n < 1400; n++) begin
            @(negedge CLK);
            if (ADC_START === 1'b1) break;
        end
        check("pacing period", n, TIMER_PERIOD);
    endtask : t_pacing

    task automatic t_conv(input logic qx, input logic qy, input logic [23:0] ph, input logic [20:0] ofs);
        int i;
        @(posedge CLK);
        HALL_QUADRANT_X <= qx;
        HALL_QUADRANT_Y <= qy;
        ANGLE_OFFSET <= ofs;
        wait_start();
        for (i = 0; i < AVG_COUNT; i++) begin
            @(posedge CLK);
            ADC_VALID <= 1'b1;
            ADC_SIN <= 12'(12'h800 + i);
            ADC_COS <= 12'h7C0;
        end
        @(posedge CLK);
        ADC_VALID <= 1'b0;
        @(negedge CLK);
        check("atan start", ATAN_START, 1);
        // ramp mean is 0x800 plus 31.5, truncated
        check("atan sin", ATAN_SIN, 13'sh001F);
        check("atan cos", ATAN_COS, 13'sh1FC0);
        @(posedge CLK);
        ATAN_DONE <= 1'b1;
        ATAN_PHASE <= ph;
        @(posedge CLK);
        ATAN_DONE <= 1'b0;
        @(negedge CLK);
        check("angle", ANGLE, exp_angle(qx, qy, ph, ofs));
    endtask : t_conv

    task automatic t_frame;
        logic [7:0] b, crc;
        logic [7:0] eb [11];
        logic ok;
        logic [20:0] ang;
        int i, j;
        aael_host_inst.send_byte(8'h04);
        for (i = 0; i < 300; i++) begin
            @(negedge CLK);
            if (TX_OE !== 1'b0) break;
        end
        check("quiet on other command", i, 300);
        ang = ANGLE;
        eb = '{REQ, STATUS_FULL_TURN, ang[7:0], ang[15:8], {3'h0, ang[20:16]}, ENC_ID, 8'h00, 8'h00, 8'h00,
               8'h00, 8'h00};
        crc = 8'h00;
        for (i = 0; i < 10; i++) begin
            crc = crc ^ eb[i];
            for (j = 0; j < 8; j++) crc = crc[7] ? ({crc[6:0], 1'b0} ^ 8'h07) : {crc[6:0], 1'b0};
        end
        eb[10] = crc;
        aael_host_inst.send_byte(REQ);
        for (i = 0; i < RESP_BYTES; i++) begin
            aael_host_inst.recv_byte(b, ok);
            check("byte framing", ok, 1);
            check("reply byte", b, eb[i]);
        end
        for (i = 0; i < 20 && TX_OE !== 1'b0; i++) @(negedge CLK);
        check("driver released", TX_OE, 0);
    endtask : t_frame

    initial begin
        repeat (3) @(posedge CLK);
        RESET_N <= 1'b1;
        t_pacing();
        t_conv(1'b0, 1'b0, 24'h000000, 21'h000000);
        t_conv(1'b1, 1'b1, 24'hF80000, 21'h000000);
        t_conv(1'b0, 1'b1, 24'h080000, 21'h001000);
        check("turn not yet seen", FULL_TURN_SEEN, 0);
        t_conv(1'b1, 1'b0, 24'hF00000, 21'h000000);
        check("turn seen", FULL_TURN_SEEN, 1);
        t_frame();
        end_sim();
    end
endmodule : aael_top_tb
